//--- src/srs_status_system.sv
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
// Function
// - Condition bits are the live instrument state, read-only, never latched.
// - An event sets its event bit; repeats are ignored while set.
// - Event bits stay set until query clear or clear-all; host cannot write them.
// - Set summary bit is OR of event bits ANDed with enable bits.
// - Every enable register is host writable and readable.
// - Status byte is read-only and non-latching, following the summaries.
// - Master summary bit set when any summary bit meets its service enable bit.
// - Service request line follows the master summary bit.
// - Service request enable mask is host writable and readable.
// - Status byte read reports any enabled summary via master summary bit.
// - Register reads return the 8-bit binary weighted value, bit 7 weight 128.
// - Only enable registers accept writes; written value loads as bit pattern. The control word also takes writes, bit 0 clearing every event register.
// - Standard event set has no condition register; operation set has one.
// - Reading standard events clears them; clear-all clears every event register.
// - Writing zero clears an enable register; all enables clear at reset.
// - Standard events: power-on 7, command 5, execution 4, query 2, complete 0.
// - Serial poll returns the status byte between poll enable and disable.
module srs_status_system (
	input  wire logic                  ref_clk,
	input  wire logic                  rst,
	input  wire logic                  clk_en,
	input  wire srs_pkg::srs_axi_req_t axi_req,
	output srs_pkg::srs_axi_rsp_t      axi_rsp,
	input  wire logic                  ev_power_on,
	input  wire logic                  ev_cmd_err,
	input  wire logic                  ev_exec_err,
	input  wire logic                  ev_query_err,
	input  wire logic                  ev_op_complete,
	input  wire logic [7:0]            op_cond_in,
	input  wire logic                  poll_active,
	output logic [7:0]                 poll_byte,
	output logic                       srq_out,
	output logic                       irq
);
	import srs_pkg::*;

	// Register map, one 32-bit word per register, data in bits 7:0
	//   Status byte: read-only, rebuilt every cycle from the summaries
	//   Bit 5 is the standard summary, bit 7 the operation summary
	//   Bit 6 is the master summary, the OR of summaries under the service mask
	//   Service request mask: read and write, bit 6 always reads zero
	//   Standard events: read-only, a read returns the bits and clears them
	//   Standard enable: read and write, selects events for the standard summary
	//   Operation condition: read-only, the synchronised live condition inputs
	//   Operation events: read-only, a read returns the bits and clears them
	//   Operation enable: read and write, selects events for the operation summary
	//   Control: write bit 0 high to clear every event register, reads zero
	//   Interrupt status: sticky sources, cleared by a read of this word
	//   Interrupt mask: read and write, bits 2:0 gate the interrupt line
	//   Any other word: refused with a slave error and no side effect
	//
	// Register bus timing
	//   Address and data may arrive in either order, each held once taken
	//   Once both are held, the write is performed on the next edge
	//   The write answer stands from then until the master accepts it
	//   A read is taken whenever no read answer is pending
	//   Read data are captured on the taking edge and shown one cycle later
	//   The read answer stands until the master accepts it
	//   Only byte lane 0 carries register data; other lanes are ignored
	//   Writes to read-only words are answered OKAY and change nothing
	//   One write and one read may be under way at the same time
	//
	// Event capture
	//   Standard event inputs are sampled on every enabled edge
	//   A held input keeps setting its bit, which is harmless
	//   Operation events come from a rising edge of a synchronised condition
	//   The edge is taken between the second stage and its last value,
	//   so the first synchroniser stage feeds nothing but the second
	//   Event bits stay set until a clearing read or the clear control
	//   A new event in the cycle of its clear wins, so nothing is lost
	//
	// Summaries and the service request line
	//   Each summary is the OR of its events ANDed with their enables
	//   The status byte holds no state of its own and cannot go stale
	//   The service request line is the master summary bit itself
	//   A cleared event drops its summary and the line in the same cycle
	//
	// Interrupts
	//   Bit 0 records a rise of the master summary
	//   Bit 1 records a newly set standard event bit
	//   Bit 2 records a newly set operation event bit
	//   A source arriving during the clearing read stays recorded
	//   The interrupt line is high while a masked-in status bit is set
	//
	// Serial poll
	//   The poll byte follows the status byte one cycle behind
	//   While a poll is active it is frozen, so the controller sees one value
	//
	// Clock enable and reset
	//   With the clock enable low no state moves, bus answers included
	//   Reset clears every register, enables and masks included
	//   Power-on is an input event; reset does not raise it by itself
	//
	// Limitations
	//   Condition inputs narrower than one cycle may be missed
	//   Handshake outputs are decoded from state and may change every cycle

	srs_state_t s_q;
	srs_state_t s_d;

	logic [7:0] std_set;
	logic [7:0] op_set;
	logic [7:0] status_byte;
	logic       esb_sum;
	logic       op_sum;
	logic       rqs;
	logic       wr_fire;
	logic       rd_fire;
	logic [2:0] irq_ev;

	// Apply byte-lane 0 of a write to an 8-bit register
	function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] data, input logic [3:0] strb);
		lane0 = strb[0] ? data[7:0] : old;
	endfunction

	// Word-aligned register address, low two bits ignored
	function automatic logic [7:0] word_addr(input logic [7:0] addr);
		word_addr = {addr[7:2], 2'b00};
	endfunction

	// Latch new events, then drop bits being cleared unless re-hit this cycle
	function automatic logic [7:0] evt_next(input logic [7:0] cur, input logic [7:0] hit, input logic clr);
		evt_next = (clr ? 8'h00 : cur) | hit;
	endfunction

	// Standard event inputs placed at fixed bit positions
	always_comb begin
		std_set = 8'h00;
		std_set[BIT_PON] = ev_power_on;
		std_set[BIT_CME] = ev_cmd_err;
		std_set[BIT_EXE] = ev_exec_err;
		std_set[BIT_QYE] = ev_query_err;
		std_set[BIT_OPC] = ev_op_complete;
	end

	// Operation events: rising edge of a synchronised condition bit
	// Compared with its own last value, never with the first stage
	assign op_set = s_q.op_cond_q & ~s_q.op_cond_prev_q;

	// Summaries and the non-latching status byte
	assign esb_sum = |(s_q.std_evt_q & s_q.std_en_q);
	assign op_sum  = |(s_q.op_evt_q & s_q.op_en_q);
	always_comb begin
		status_byte = 8'h00;
		status_byte[STB_ESB] = esb_sum;
		status_byte[STB_OP]  = op_sum;
		status_byte[STB_RQS] = |(status_byte & s_q.sre_q);
	end
	assign rqs     = status_byte[STB_RQS];
	assign srq_out = rqs;
	assign irq     = |(s_q.irq_stat_q & s_q.irq_mask_q);

	// Bus handshakes
	assign wr_fire = (s_q.wphase_q == SRS_IDLE) && s_q.aw_got_q && s_q.w_got_q;
	assign rd_fire = (s_q.rphase_q == SRS_IDLE) && axi_req.arvalid;
	always_comb begin
		axi_rsp         = '0;
		axi_rsp.awready = (s_q.wphase_q == SRS_IDLE) && !s_q.aw_got_q;
		axi_rsp.wready  = (s_q.wphase_q == SRS_IDLE) && !s_q.w_got_q;
		axi_rsp.bvalid  = (s_q.wphase_q == SRS_WRESP);
		axi_rsp.bresp   = s_q.bresp_q;
		axi_rsp.arready = (s_q.rphase_q == SRS_IDLE);
		axi_rsp.rvalid  = (s_q.rphase_q == SRS_RRESP);
		axi_rsp.rdata   = s_q.rdata_q;
		axi_rsp.rresp   = s_q.rresp_q;
	end

	// Serial poll byte held from flip-flops while polling
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			poll_byte <= 8'h00;
		end else if (clk_en && !poll_active) begin
			poll_byte <= status_byte;
		end
	end

	// Next-state logic
	always_comb begin
		logic       clr_std;
		logic       clr_op;
		logic       clr_irq;
		logic       clr_all;
		logic [7:0] op_rise;
		clr_std = 1'b0;
		clr_op  = 1'b0;
		clr_irq = 1'b0;
		clr_all = 1'b0;
		op_rise = op_set;
		s_d = s_q;

		// Condition bits: two-stage synchroniser, no latching
		s_d.op_cond_s1_q = op_cond_in;
		s_d.op_cond_q    = s_q.op_cond_s1_q;
		// Last synchronised value, for edge detection
		s_d.op_cond_prev_q = s_q.op_cond_q;

		// Capture write address and data in either order
		if (axi_rsp.awready && axi_req.awvalid) begin
			s_d.aw_got_q = 1'b1;
			s_d.awaddr_q = axi_req.awaddr;
		end
		if (axi_rsp.wready && axi_req.wvalid) begin
			s_d.w_got_q = 1'b1;
			s_d.wdata_q = axi_req.wdata;
			s_d.wstrb_q = axi_req.wstrb;
		end

		// Register writes: only enable registers and controls accept data
		if (wr_fire) begin
			s_d.aw_got_q = 1'b0;
			s_d.w_got_q  = 1'b0;
			s_d.wphase_q = SRS_WRESP;
			s_d.bresp_q  = RESP_OKAY;
			case (word_addr(s_q.awaddr_q))
				ADDR_SRE: begin
					s_d.sre_q = lane0(s_q.sre_q, s_q.wdata_q, s_q.wstrb_q) & ~(8'h01 << STB_RQS);
				end
				ADDR_STD_EN: begin
					s_d.std_en_q = lane0(s_q.std_en_q, s_q.wdata_q, s_q.wstrb_q);
				end
				ADDR_OP_EN: begin
					s_d.op_en_q = lane0(s_q.op_en_q, s_q.wdata_q, s_q.wstrb_q);
				end
				ADDR_CTRL: begin
					clr_all = s_q.wstrb_q[0] && s_q.wdata_q[CTRL_CLEAR_ALL];
				end
				ADDR_IRQ_MASK: begin
					if (s_q.wstrb_q[0]) begin
						s_d.irq_mask_q = s_q.wdata_q[2:0];
					end
				end
				ADDR_STB, ADDR_STD_EVT, ADDR_OP_COND, ADDR_OP_EVT, ADDR_IRQ_STAT: begin
					s_d.bresp_q = RESP_OKAY; // read-only, write ignored
				end
				default: begin
					s_d.bresp_q = RESP_SLVERR;
				end
			endcase
		end else if (s_q.wphase_q == SRS_WRESP && axi_req.bready) begin
			s_d.wphase_q = SRS_IDLE;
		end

		// Register reads, with clear-on-read side effects
		if (rd_fire) begin
			s_d.rphase_q = SRS_RRESP;
			s_d.rresp_q  = RESP_OKAY;
			s_d.rdata_q  = 32'h00000000;
			case (word_addr(axi_req.araddr))
				ADDR_STB: begin
					s_d.rdata_q[7:0] = status_byte;
				end
				ADDR_SRE: begin
					s_d.rdata_q[7:0] = s_q.sre_q;
				end
				ADDR_STD_EVT: begin
					s_d.rdata_q[7:0] = s_q.std_evt_q;
					clr_std = 1'b1;
				end
				ADDR_STD_EN: begin
					s_d.rdata_q[7:0] = s_q.std_en_q;
				end
				ADDR_OP_COND: begin
					s_d.rdata_q[7:0] = s_q.op_cond_q;
				end
				ADDR_OP_EVT: begin
					s_d.rdata_q[7:0] = s_q.op_evt_q;
					clr_op = 1'b1;
				end
				ADDR_OP_EN: begin
					s_d.rdata_q[7:0] = s_q.op_en_q;
				end
				ADDR_CTRL: begin
					s_d.rdata_q = 32'h00000000;
				end
				ADDR_IRQ_STAT: begin
					s_d.rdata_q[2:0] = s_q.irq_stat_q;
					clr_irq = 1'b1;
				end
				ADDR_IRQ_MASK: begin
					s_d.rdata_q[2:0] = s_q.irq_mask_q;
				end
				default: begin
					s_d.rresp_q = RESP_SLVERR;
				end
			endcase
		end else if (s_q.rphase_q == SRS_RRESP && axi_req.rready) begin
			s_d.rphase_q = SRS_IDLE;
		end

		// Event latching: set wins over clear
		s_d.std_evt_q = evt_next(s_q.std_evt_q, std_set, clr_std | clr_all);
		s_d.op_evt_q  = evt_next(s_q.op_evt_q, op_rise | op_set, clr_op | clr_all);

		// Interrupt sources: new events and a rising service request
		irq_ev = 3'h0;
		irq_ev[IRQ_RQS_RISE] = rqs && !s_q.rqs_prev_q;
		irq_ev[IRQ_STD_EVT]  = |(std_set & ~s_q.std_evt_q);
		irq_ev[IRQ_OP_EVT]   = |(op_rise & ~s_q.op_evt_q);
		s_d.irq_stat_q = (clr_irq ? 3'h0 : s_q.irq_stat_q) | irq_ev;
		s_d.rqs_prev_q = rqs;
	end

	// State register with clock enable
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_q <= RST_STATE;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

endmodule

//--- include/srs_pkg.sv
package srs_pkg;

	// Register byte offsets
	localparam logic [7:0] ADDR_STB      = 8'h00;
	localparam logic [7:0] ADDR_SRE      = 8'h04;
	localparam logic [7:0] ADDR_STD_EVT  = 8'h08;
	localparam logic [7:0] ADDR_STD_EN   = 8'h0C;
	localparam logic [7:0] ADDR_OP_COND  = 8'h10;
	localparam logic [7:0] ADDR_OP_EVT   = 8'h14;
	localparam logic [7:0] ADDR_OP_EN    = 8'h18;
	localparam logic [7:0] ADDR_CTRL     = 8'h1C;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;

	// Standard event bit positions
	localparam int BIT_PON = 7;
	localparam int BIT_CME = 5;
	localparam int BIT_EXE = 4;
	localparam int BIT_QYE = 2;
	localparam int BIT_OPC = 0;

	// Status byte bit positions
	localparam int STB_OP  = 7;
	localparam int STB_RQS = 6;
	localparam int STB_ESB = 5;

	// Control register bits
	localparam int CTRL_CLEAR_ALL = 0;

	// Interrupt status bit positions
	localparam int IRQ_RQS_RISE = 0;
	localparam int IRQ_STD_EVT  = 1;
	localparam int IRQ_OP_EVT   = 2;

	// Reset values and response codes
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		SRS_IDLE  = 3'b001,
		SRS_WRESP = 3'b010,
		SRS_RRESP = 3'b100
	} srs_phase_t;

	// AXI4-Lite request side
	typedef struct packed {
		logic [7:0]  awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [7:0]  araddr;
		logic        arvalid;
		logic        rready;
	} srs_axi_req_t;

	// AXI4-Lite response side
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} srs_axi_rsp_t;

	// All state of the block except the poll byte
	typedef struct packed {
		logic [7:0]  std_evt_q;
		logic [7:0]  std_en_q;
		logic [7:0]  op_evt_q;
		logic [7:0]  op_en_q;
		logic [7:0]  sre_q;
		logic [7:0]  op_cond_s1_q;
		logic [7:0]  op_cond_q;
		logic [7:0]  op_cond_prev_q;
		logic [2:0]  irq_stat_q;
		logic [2:0]  irq_mask_q;
		logic        rqs_prev_q;
		logic        aw_got_q;
		logic [7:0]  awaddr_q;
		logic        w_got_q;
		logic [31:0] wdata_q;
		logic [3:0]  wstrb_q;
		logic [1:0]  bresp_q;
		logic [31:0] rdata_q;
		logic [1:0]  rresp_q;
		srs_phase_t  wphase_q;
		srs_phase_t  rphase_q;
	} srs_state_t;

	localparam srs_state_t RST_STATE = '{
		std_evt_q: RST_BYTE, std_en_q: RST_BYTE, op_evt_q: RST_BYTE, op_en_q: RST_BYTE,
		sre_q: RST_BYTE, op_cond_s1_q: RST_BYTE, op_cond_q: RST_BYTE, op_cond_prev_q: RST_BYTE,
		irq_stat_q: 3'h0, irq_mask_q: 3'h0, rqs_prev_q: 1'b0,
		aw_got_q: 1'b0, awaddr_q: 8'h00, w_got_q: 1'b0, wdata_q: 32'h00000000, wstrb_q: 4'h0,
		bresp_q: RESP_OKAY, rdata_q: 32'h00000000, rresp_q: RESP_OKAY,
		wphase_q: SRS_IDLE, rphase_q: SRS_IDLE
	};

endpackage

//--- testbench/srs_status_sva.sv
`timescale 1ns/1ns
// Bus handshake and poll snapshot checks at the pins
module srs_status_sva (
	input wire logic                  ref_clk,
	input wire logic                  rst,
	input wire srs_pkg::srs_axi_req_t axi_req,
	input wire srs_pkg::srs_axi_rsp_t axi_rsp,
	input wire logic                  poll_active,
	input wire logic [7:0]            poll_byte,
	input wire logic                  srq_out
);
	import srs_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Address and data taken together
	sequence s_wr_take;
		axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
	endsequence
	sequence s_rd_take;
		axi_req.arvalid && axi_rsp.arready;
	endsequence
	a_wr_answer: assert property (s_wr_take |-> ##2 axi_rsp.bvalid)
		else $error("write answer late");
	a_wr_block: assert property (s_wr_take |=> !axi_rsp.awready && !axi_rsp.wready)
		else $error("write channel not blocked");
	a_rd_answer: assert property (s_rd_take |=> axi_rsp.rvalid && !axi_rsp.arready)
		else $error("read answer late");
	a_rd_hold: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
		else $error("read data not held");
	a_b_hold: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
		else $error("write answer not held");
	a_rd_upper: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	a_rd_unmapped: assert property (s_rd_take ##0 ({axi_req.araddr[7:2], 2'b00} > ADDR_IRQ_MASK) |=> axi_rsp.rresp == RESP_SLVERR)
		else $error("unmapped read not refused");
	a_poll_track: assert property (!poll_active |=> poll_byte[STB_RQS] == $past(srq_out))
		else $error("poll byte lost service request");
	a_poll_freeze: assert property (poll_active |=> $stable(poll_byte))
		else $error("poll byte moved during poll");
endmodule
bind srs_status_system srs_status_sva u_sva (.ref_clk(ref_clk), .rst(rst), .axi_req(axi_req), .axi_rsp(axi_rsp),
	.poll_active(poll_active), .poll_byte(poll_byte), .srq_out(srq_out));

//--- testbench/srs_host_model.sv
`timescale 1ns/1ns
// Bus controller side: one transfer at a time
module srs_host_model (
	input  wire logic                  ref_clk,
	input  wire srs_pkg::srs_axi_rsp_t axi_rsp,
	output srs_pkg::srs_axi_req_t      axi_req
);
	import srs_pkg::*;
	// Idle master
	initial axi_req = '0;
	// Each channel is released at the edge that takes it
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic [1:0] rs);
		logic ta, tw, tr, done;
		done = 1'b0;
		@(posedge ref_clk);
		axi_req.awaddr <= a;
		axi_req.araddr <= a;
		axi_req.wdata <= d;
		axi_req.wstrb <= 4'hF;
		axi_req.awvalid <= wr;
		axi_req.wvalid <= wr;
		axi_req.bready <= wr;
		axi_req.arvalid <= !wr;
		axi_req.rready <= !wr;
		while (!done) begin
			@(negedge ref_clk);
			ta = axi_req.awvalid && axi_rsp.awready;
			tw = axi_req.wvalid && axi_rsp.wready;
			tr = axi_req.arvalid && axi_rsp.arready;
			done = (axi_req.bready && axi_rsp.bvalid) || (axi_req.rready && axi_rsp.rvalid);
			q = axi_rsp.rdata;
			rs = wr ? axi_rsp.bresp : axi_rsp.rresp;
			@(posedge ref_clk);
			if (ta) axi_req.awvalid <= 1'b0;
			if (tw) axi_req.wvalid <= 1'b0;
			if (tr) axi_req.arvalid <= 1'b0;
			if (done) axi_req.bready <= 1'b0;
			if (done) axi_req.rready <= 1'b0;
		end
	endtask
endmodule

//--- testbench/srs_status_system_tb.sv
`timescale 1ns/1ns
module srs_status_system_tb;
	import srs_pkg::*;
	logic         ref_clk = 1'b0;
	logic         rst = 1'b1;
	logic         poll = 1'b0;
	logic         en = 1'b1;
	logic [7:0]   ev_v = 8'h00;
	logic [7:0]   cond = 8'h00;
	srs_axi_req_t req;
	srs_axi_rsp_t rsp;
	logic [7:0]   pbyte;
	logic         srq;
	logic         irq;
	logic [31:0]  q;
	logic [1:0]   rs;
	int           fails = 0;
	int           total_checks = 0;
	int           seed = 32'h528fe174;
	int           sev, sen, oev, oen, sre, ist, imk, c, mp, pb, n;
	logic [7:0]   ens [3] = '{ADDR_SRE, ADDR_STD_EN, ADDR_OP_EN};
	logic [7:0]   ros [4] = '{ADDR_STB, ADDR_STD_EVT, ADDR_OP_COND, ADDR_OP_EVT};
	int           bits [5] = '{BIT_PON, BIT_CME, BIT_EXE, BIT_QYE, BIT_OPC};
	// Clock
	always #25 ref_clk = ~ref_clk;
	srs_status_system DUT (.ref_clk(ref_clk), .rst(rst), .clk_en(en), .axi_req(req), .axi_rsp(rsp),
		.ev_power_on(ev_v[7]), .ev_cmd_err(ev_v[5]), .ev_exec_err(ev_v[4]), .ev_query_err(ev_v[2]),
		.ev_op_complete(ev_v[0]), .op_cond_in(cond), .poll_active(poll), .poll_byte(pbyte),
		.srq_out(srq), .irq(irq));
	srs_host_model host (.ref_clk(ref_clk), .axi_rsp(rsp), .axi_req(req));
	// Model status byte
	function automatic int stb();
		int s;
		s = (((sev & sen) != 0) << STB_ESB) | (((oev & oen) != 0) << STB_OP);
		return s | (((s & sre) != 0) << STB_RQS);
	endfunction
	function automatic int exp_rd(logic [7:0] a);
		case (a)
			ADDR_STB: return stb();
			ADDR_SRE: return sre;
			ADDR_STD_EVT: return sev;
			ADDR_STD_EN: return sen;
			ADDR_OP_COND: return c;
			ADDR_OP_EVT: return oev;
			ADDR_OP_EN: return oen;
			ADDR_IRQ_STAT: return ist;
			ADDR_IRQ_MASK: return imk;
			default: return 0;
		endcase
	endfunction
	// Service request rise flag
	function automatic void track();
		if (((stb() >> STB_RQS) & 1) > mp) ist |= 1;
		mp = (stb() >> STB_RQS) & 1;
	endfunction
	task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			fails++;
			$display("mismatch %s expected %0h seen %0h", nm, e, s);
		end
	endtask
	task automatic chk_pin(string nm, logic e, logic s);
		chk(nm, {31'h0, e}, {31'h0, s});
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic rd(logic [7:0] a);
		n = exp_rd(a);
		host.xfer(1'b0, a, 32'h0, q, rs);
		chk($sformatf("register %0h", a), n, q);
		if (a == ADDR_STD_EVT) sev = 0;
		if (a == ADDR_OP_EVT) oev = 0;
		if (a == ADDR_IRQ_STAT) ist = 0;
		track();
	endtask
	task automatic wr(logic [7:0] a, int d);
		host.xfer(1'b1, a, d, q, rs);
		chk("write response", RESP_OKAY, rs);
		case (a)
			ADDR_SRE: sre = d & 8'hBF;
			ADDR_STD_EN: sen = d & 8'hFF;
			ADDR_OP_EN: oen = d & 8'hFF;
			ADDR_IRQ_MASK: imk = d & 3'h7;
			ADDR_CTRL: sev = (d & 1) ? 0 : sev;
			default: ;
		endcase
		oev = (a == ADDR_CTRL && (d & 1)) ? 0 : oev;
		track();
	endtask
	task automatic pulse(int b);
		@(posedge ref_clk);
		ev_v <= 8'(1 << b);
		@(posedge ref_clk);
		ev_v <= 8'h00;
		sev |= 1 << b;
		ist |= 2;
		track();
	endtask
	task automatic pins();
		repeat (2) @(negedge ref_clk);
		chk_pin("service request", 1'(stb() >> STB_RQS), srq);
		chk_pin("interrupt", (ist & imk) != 0, irq);
	endtask
	// Watchdog
	initial begin
		#400000;
		fails++;
		complete_run();
	end
	// Main sequence
	initial begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		for (int a = 0; a <= 'h24; a += 4) rd(8'(a));
		host.xfer(1'b0, 8'h28, 32'h0, q, rs);
		chk("unmapped response", RESP_SLVERR, rs);
		wr(ADDR_IRQ_MASK, 3'h7);
		foreach (ens[i]) begin
			wr(ens[i], $random(seed));
			rd(ens[i]);
		end
		foreach (ros[i]) begin
			wr(ros[i], 32'hFFFFFFFF);
			rd(ros[i]);
		end
		foreach (bits[i]) begin
			pulse(bits[i]);
			pulse(bits[i]);
			pins();
			rd(ADDR_STB);
			rd(ADDR_STD_EVT);
			rd(ADDR_STD_EVT);
			rd(ADDR_IRQ_STAT);
		end
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk);
			n = $random(seed) & 8'hFF;
			cond <= 8'(n);
			if ((n & ~c & ~oev) != 0) ist |= 4;
			oev |= n & ~c;
			c = n;
			track();
			repeat (4) @(posedge ref_clk);
			rd(ADDR_OP_COND);
			rd(ADDR_STB);
			pins();
		end
		pulse(BIT_CME);
		wr(ADDR_CTRL, 1);
		foreach (ros[i]) rd(ros[i]);
		wr(ADDR_STD_EN, 1 << BIT_CME);
		wr(ADDR_SRE, 1 << STB_ESB);
		pulse(BIT_CME);
		pins();
		rd(ADDR_STB);
		rd(ADDR_IRQ_STAT);
		pb = stb();
		rd(ADDR_STD_EVT);
		pins();
		@(posedge ref_clk);
		poll <= 1'b1;
		pb = stb();
		pulse(BIT_CME);
		pins();
		chk("poll byte", pb, pbyte);
		@(posedge ref_clk);
		poll <= 1'b0;
		repeat (2) @(negedge ref_clk);
		chk("poll byte", stb(), pbyte);
		foreach (ens[i]) begin
			wr(ens[i], 0);
			rd(ens[i]);
		end
		// Clock enable low: an event must not be captured
		@(posedge ref_clk);
		en <= 1'b0;
		ev_v <= 8'(1 << BIT_EXE);
		repeat (3) @(posedge ref_clk);
		en <= 1'b1;
		ev_v <= 8'h00;
		rd(ADDR_STD_EVT);
		complete_run();
	end
endmodule
